// File: design/hpc_config.sv
// host pin configuration register with its bus port and pin shaping
// assumes bus strobes and data are held steady for more than three clocks
module hpc_config
  import hpc_pkg::*;
#(
  parameter int NIRQ      = 8,                     // interrupt status width
  parameter int PULSE_CYC = HPC_IRQ_PULSE_CYC      // edge-mode pulse length
) (
  input  wire logic            i_clk_sys,
  input  wire logic            i_nrst,
  // shared processor bus pins
  input  wire logic            i_cs_n,
  input  wire logic            i_rd_n,
  input  wire logic            i_wr_n,
  input  wire logic            i_a0,             // 1 command, 0 data
  input  wire logic [15:0]     i_data,
  output logic      [15:0]     o_data,
  output logic                 o_data_oe,
  // dma pins and internal dma side
  input  wire logic            i_end_of_transfer_pin,
  input  wire logic            i_host_dma_ack_pin,
  input  wire logic            i_dma_request,    // internal, active high
  output logic                 o_dma_request_pin,
  output logic                 o_end_of_transfer, // internal, active high
  output logic                 o_dma_read,       // acked read strobe
  output logic                 o_dma_write,      // acked write strobe
  // interrupt status from the status logic, same clock
  input  wire logic [NIRQ-1:0] i_irq_status,
  input  wire logic [NIRQ-1:0] i_processor_irq_mask,
  output logic                 o_host_irq_pin,
  // configuration to the port and clock logic
  output logic                 o_port_pulldown_select,
  output logic                 o_suspend_clock_keep,
  output logic                 o_analog_overcurrent_select,
  output logic                 o_bus_width_ok
);

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  localparam int SW = 22;                          // strobes, data, dma inputs
  localparam logic [SW-1:0] SYNC_RST = 22'h3C000F;  // strobes, a0, data bits 15..14 and dma pins at 1

  logic [SW-1:0] pins_s;                           // synchronised pin group
  logic          cs_n_s;                           // chip select, synced
  logic          rd_n_s;                           // read strobe, synced
  logic          wr_n_s;                           // write strobe, synced
  logic          a0_s;                             // command/data select
  logic [15:0]   data_s;                           // write data, synced
  logic          eot_pin_s;                        // end-of-transfer pin
  logic          ack_pin_s;                        // dma ack pin

  hpc_sync #(.W(SW), .RST_VAL(SYNC_RST)) u_sync (
    .i_clk_sys (i_clk_sys),
    .i_nrst    (i_nrst),
    .i_async   ({i_end_of_transfer_pin, i_host_dma_ack_pin, i_data,
                 i_a0, i_wr_n, i_rd_n, i_cs_n}),
    .o_sync    (pins_s)
  );

  assign cs_n_s    = pins_s[0];
  assign rd_n_s    = pins_s[1];
  assign wr_n_s    = pins_s[2];
  assign a0_s      = pins_s[3];
  assign data_s    = pins_s[19:4];
  assign ack_pin_s = pins_s[20];
  assign eot_pin_s = pins_s[21];

  //////////////////////////////////////////////////////////////////////////////
  // bus decode

  logic        wr_n_prev_q;                        // strobe history for edge
  logic [7:0]  cmd_q;                              // last command code
  logic [15:0] cfg_q;                              // the register itself
  logic [15:0] cfg_d;
  logic        wr_end;                             // write strobe just released
  logic        cmd_wr;                             // command phase write
  logic        cfg_wr;                             // data write to register
  logic        cfg_rd;                             // data read of register

  // data latched at the end of the strobe, when it is surely settled
  assign wr_end = wr_n_s && !wr_n_prev_q && !cs_n_s;
  assign cmd_wr = wr_end && a0_s;
  assign cfg_wr = wr_end && !a0_s && (cmd_q == HPC_CMD_WRITE);
  assign cfg_rd = !cs_n_s && !rd_n_s && !a0_s && (cmd_q == HPC_CMD_READ);

  assign cfg_d = cfg_wr ? (data_s & HPC_WRITE_MASK) : cfg_q;

  // strobe history and command latch
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      wr_n_prev_q <= 1'b1;
      cmd_q       <= 8'h00;
    end else begin
      wr_n_prev_q <= wr_n_s;
      if (cmd_wr) begin
        cmd_q <= data_s[7:0];
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      cfg_q <= HPC_RESET_VALUE;
    end else begin
      cfg_q <= cfg_d;
    end
  end

  // read data from a flop; enable follows the decoded read
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_data <= 16'h0000;
    end else begin
      o_data <= cfg_q;
    end
  end

  assign o_data_oe = cfg_rd;

  //////////////////////////////////////////////////////////////////////////////
  // static configuration outputs

  assign o_port_pulldown_select      = cfg_q[HPC_POS_PULLDOWN];
  assign o_suspend_clock_keep        = cfg_q[HPC_POS_CLK_KEEP];
  assign o_analog_overcurrent_select = cfg_q[HPC_POS_ANA_OC];
  assign o_bus_width_ok = cfg_q[HPC_POS_WIDTH_HI:HPC_POS_WIDTH_LO] == HPC_WIDTH_16;

  //////////////////////////////////////////////////////////////////////////////
  // dma pin levels

  logic ack_active;                                // ack asserted, normal mode

  assign o_dma_request_pin = i_dma_request ~^ cfg_q[HPC_POS_REQ_LVL];
  assign o_end_of_transfer = eot_pin_s ~^ cfg_q[HPC_POS_EOT_LVL];
  // ack level; reserved setting 1 never asserts, a safe answer
  assign ack_active  = !ack_pin_s && !cfg_q[HPC_POS_ACK_LVL] && !cfg_q[HPC_POS_ACK_MODE];
  assign o_dma_read  = ack_active && !rd_n_s;
  assign o_dma_write = ack_active && !wr_n_s;

  //////////////////////////////////////////////////////////////////////////////
  // interrupt pin

  logic       pending;                             // gated, masked request
  logic       pending_q;                           // for rising-edge detect
  logic [7:0] pulse_q;                             // edge pulse countdown
  logic       irq_active;                          // pin asserted, any level

  assign pending = |(i_irq_status & i_processor_irq_mask) && cfg_q[HPC_POS_IRQ_GATE];

  // edge mode pulse; a new edge restarts it
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      pending_q <= 1'b0;
      pulse_q   <= 8'h00;
    end else begin
      pending_q <= pending;
      if (pending && !pending_q) begin
        pulse_q <= 8'(PULSE_CYC);
      end else if (pulse_q != 8'h00) begin
        pulse_q <= pulse_q - 8'h01;
      end
    end
  end

  assign irq_active     = cfg_q[HPC_POS_IRQ_EDGE] ? (pulse_q != 8'h00) && pending : pending;
  assign o_host_irq_pin = irq_active ~^ cfg_q[HPC_POS_IRQ_LVL];

  //////////////////////////////////////////////////////////////////////////////
  // assertions

  property p_reserved_zero;
    @(posedge i_clk_sys) disable iff (!i_nrst)
    (cfg_q & ~HPC_WRITE_MASK) == 16'h0000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

  property p_write_lands;
    @(posedge i_clk_sys) disable iff (!i_nrst)
    cfg_wr |=> cfg_q == ($past(data_s) & HPC_WRITE_MASK);
  endproperty
  a_write_lands: assert property (p_write_lands) else $error("write not stored");

  property p_pulldown;
    @(posedge i_clk_sys) disable iff (!i_nrst)
    cfg_wr |=> o_port_pulldown_select == $past(data_s[HPC_POS_PULLDOWN]);
  endproperty
  a_pulldown: assert property (p_pulldown) else $error("pull-down select wrong");

  property p_clk_keep;
    @(posedge i_clk_sys) disable iff (!i_nrst)
    cfg_wr |=> o_suspend_clock_keep == $past(data_s[HPC_POS_CLK_KEEP]);
  endproperty
  a_clk_keep: assert property (p_clk_keep) else $error("clock keep wrong");

  property p_ana_oc;
    @(posedge i_clk_sys) disable iff (!i_nrst)
    cfg_wr |=> o_analog_overcurrent_select == $past(data_s[HPC_POS_ANA_OC]);
  endproperty
  a_ana_oc: assert property (p_ana_oc) else $error("overcurrent select wrong");

  property p_ack_strobe;
    @(posedge i_clk_sys) disable iff (!i_nrst)
    cfg_q[HPC_POS_ACK_MODE] |-> !o_dma_read && !o_dma_write;
  endproperty
  a_ack_strobe: assert property (p_ack_strobe) else $error("ack used in reserved mode");

  property p_req_level;
    @(posedge i_clk_sys) disable iff (!i_nrst)
    i_dma_request |-> o_dma_request_pin == cfg_q[HPC_POS_REQ_LVL];
  endproperty
  a_req_level: assert property (p_req_level) else $error("request level wrong");

  property p_gate_off;
    @(posedge i_clk_sys) disable iff (!i_nrst)
    !cfg_q[HPC_POS_IRQ_GATE] |-> o_host_irq_pin == !cfg_q[HPC_POS_IRQ_LVL];
  endproperty
  a_gate_off: assert property (p_gate_off) else $error("irq pin active while gated");

  property p_irq_level;
    @(posedge i_clk_sys) disable iff (!i_nrst)
    !cfg_q[HPC_POS_IRQ_EDGE] |-> (o_host_irq_pin == cfg_q[HPC_POS_IRQ_LVL]) == pending;
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("level irq mismatch");

  property p_irq_mask;
    @(posedge i_clk_sys) disable iff (!i_nrst)
    ((i_irq_status & i_processor_irq_mask) == '0) |-> !irq_active;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("unmasked irq on pin");

  // pulse covers the four cycles after the rise, then drops while pending stays
  property p_edge_pulse;
    @(posedge i_clk_sys) disable iff (!i_nrst)
    (cfg_q[HPC_POS_IRQ_EDGE] && pending && !pending_q) ##1
      (cfg_q[HPC_POS_IRQ_EDGE] && pending)[*4] |->
      (irq_active && $past(irq_active, 3)) ##1
      (!irq_active || !cfg_q[HPC_POS_IRQ_EDGE]);
  endproperty
  a_edge_pulse: assert property (p_edge_pulse) else $error("edge pulse length wrong");

  c_write: cover property (@(posedge i_clk_sys) disable iff (!i_nrst) cfg_wr);
  c_read:  cover property (@(posedge i_clk_sys) disable iff (!i_nrst) cfg_rd);
  c_edge:  cover property (@(posedge i_clk_sys) disable iff (!i_nrst)
                           cfg_q[HPC_POS_IRQ_EDGE] && irq_active);
  c_dma:   cover property (@(posedge i_clk_sys) disable iff (!i_nrst) o_dma_read);

endmodule : hpc_config

// File: design/hpc_pkg.sv
// constants for the host pin configuration register and its pin logic
// assumes a synchronous system clock and a shared parallel processor bus
package hpc_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // command codes on the shared bus (write code is read code plus 80h)
  localparam logic [7:0]  HPC_CMD_READ     = 8'h20;  // read this register
  localparam logic [7:0]  HPC_CMD_WRITE    = 8'hA0;  // write this register

  //////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int          HPC_POS_PULLDOWN = 12;     // port pull-down source
  localparam int          HPC_POS_CLK_KEEP = 11;     // suspend clock keep
  localparam int          HPC_POS_ANA_OC   = 10;     // analog overcurrent
  localparam int          HPC_POS_ACK_MODE = 8;      // dma ack mode
  localparam int          HPC_POS_EOT_LVL  = 7;      // end-of-transfer level
  localparam int          HPC_POS_ACK_LVL  = 6;      // dma ack level
  localparam int          HPC_POS_REQ_LVL  = 5;      // dma request level
  localparam int          HPC_POS_WIDTH_HI = 4;      // bus width code msb
  localparam int          HPC_POS_WIDTH_LO = 3;      // bus width code lsb
  localparam int          HPC_POS_IRQ_LVL  = 2;      // irq output level
  localparam int          HPC_POS_IRQ_EDGE = 1;      // irq edge select
  localparam int          HPC_POS_IRQ_GATE = 0;      // irq pin gate

  //////////////////////////////////////////////////////////////////////////////
  // reset value, writable mask and the only legal width code
  localparam logic [15:0] HPC_RESET_VALUE  = 16'h0028;  // width 01, request high
  localparam logic [15:0] HPC_WRITE_MASK   = 16'h1DFF;  // bits 15..13 and 9 stay 0
  localparam logic [1:0]  HPC_WIDTH_16     = 2'h1;      // sixteen-bit bus

  //////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int          HPC_IRQ_PULSE_CYC = 4;     // edge-mode pulse length
  localparam int          HPC_SYNC_RESET    = 0;     // unused; pin flops reset to SYNC_RST

endpackage : hpc_pkg

// File: design/hpc_sync.sv
// two flip-flop synchroniser for a group of pins
// assumes each bit is a level that stays put longer than two clocks
module hpc_sync
  import hpc_pkg::*;
#(
  parameter int           W       = 1,             // number of bits
  parameter logic [W-1:0] RST_VAL = '0             // value held in reset
) (
  input  wire logic         i_clk_sys,
  input  wire logic         i_nrst,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);

  logic [W-1:0] meta_q;                            // first stage, read only below
  logic [W-1:0] sync_q;                            // second stage

  // two-stage capture; first stage feeds nothing but the second
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;

endmodule : hpc_sync

// File: verification/host_hw_config_register_tb_top.sv
// self-checking bench for the host pin configuration register
// assumes the processor model drives the bus and the bench drives all other pins
module host_hw_config_register_tb_top;
  import hpc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk = 1'b0, nrst = 1'b0, cs_n, rd_n, wr_n, a0, oe, roe;
  logic [15:0] wdata, rdata, rq;
  logic        eot_pin = 1'b1, ack_pin = 1'b1, dma_req = 1'b0;  // pins idle
  logic        req_pin, eot, dma_rd, dma_wr, irq, pd, keep, ana, wok;
  logic [7:0]  status = 8'h00, mask = 8'h00;
  int          failures = 0, total_checks = 0, cycles = 0;

  always #4 clk = ~clk;  // 125 MHz

  hpc_config hpc_config_i (.i_clk_sys(clk), .i_nrst(nrst), .i_cs_n(cs_n), .i_rd_n(rd_n),
    .i_wr_n(wr_n), .i_a0(a0), .i_data(wdata), .o_data(rdata), .o_data_oe(oe),
    .i_end_of_transfer_pin(eot_pin), .i_host_dma_ack_pin(ack_pin), .i_dma_request(dma_req),
    .o_dma_request_pin(req_pin), .o_end_of_transfer(eot), .o_dma_read(dma_rd),
    .o_dma_write(dma_wr), .i_irq_status(status), .i_processor_irq_mask(mask),
    .o_host_irq_pin(irq), .o_port_pulldown_select(pd), .o_suspend_clock_keep(keep),
    .o_analog_overcurrent_select(ana), .o_bus_width_ok(wok));

  hpc_cpu_model hpc_cpu_model_i (.i_clk_sys(clk), .i_data(rdata), .i_data_oe(oe),
    .o_cs_n(cs_n), .o_rd_n(rd_n), .o_wr_n(wr_n), .o_a0(a0), .o_data(wdata));

  ////////////////////////////////////////////////////////////////////////////////
  // shared helpers
  task automatic conclude();
    if (failures == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : conclude

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic hold(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : hold

  task automatic wr_reg(input logic [15:0] v);
    hpc_cpu_model_i.cycle(1'b1, 1'b1, {8'h00, HPC_CMD_WRITE}, rq, roe);
    hpc_cpu_model_i.cycle(1'b1, 1'b0, v, rq, roe);
  endtask : wr_reg

  task automatic rd_reg(input logic [15:0] exp);
    hpc_cpu_model_i.cycle(1'b1, 1'b1, {8'h00, HPC_CMD_READ}, rq, roe);
    hpc_cpu_model_i.cycle(1'b0, 1'b0, 16'h0000, rq, roe);
    check(rq, exp, "read word");
    check(roe, 1'b1, "bus drive");
  endtask : rd_reg

  // acked strobe with a0 0; the one data write here follows a read command and is refused
  task automatic dma_strobe(input logic wr, input logic exp);
    ack_pin = 1'b0;
    fork
      hpc_cpu_model_i.cycle(wr, 1'b0, 16'h0000, rq, roe);
      begin
        hold(4);
        check(wr ? dma_wr : dma_rd, exp, "dma strobe");
      end
    join
    ack_pin = 1'b1;
  endtask : dma_strobe

  ////////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset();
    rd_reg(16'h0028);
    check({pd, keep, ana, wok}, 4'h1, "reset config");
    check({irq, req_pin}, 2'h2, "reset pins");
  endtask : t_reset

  task automatic t_fields();
    wr_reg(16'hFFFF);
    rd_reg(16'h1DFF);
    check({pd, keep, ana, wok}, 4'hE, "all set");
    dma_strobe(1'b0, 1'b0);
    dma_req = 1'b1;
    eot_pin = 1'b1;
    hold(3);
    check({req_pin, eot}, 2'h3, "high levels");
    dma_req = 1'b0;
    eot_pin = 1'b0;
    hold(3);
    check({req_pin, eot}, 2'h0, "high idle");
    eot_pin = 1'b1;
    hpc_cpu_model_i.cycle(1'b1, 1'b1, 16'h00A1, rq, roe);
    hpc_cpu_model_i.cycle(1'b1, 1'b0, 16'h0000, rq, roe);
    rd_reg(16'h1DFF);
  endtask : t_fields

  task automatic t_dma();
    // width 01 and ack mode 0
    wr_reg(16'h0009);
    rd_reg(16'h0009);
    check({pd, keep, ana, wok}, 4'h1, "cleared");
    dma_strobe(1'b0, 1'b1);
    dma_strobe(1'b1, 1'b1);
    dma_req = 1'b1;
    eot_pin = 1'b0;
    hold(3);
    check({req_pin, eot}, 2'h1, "low levels");
    dma_req = 1'b0;
    eot_pin = 1'b1;
    hold(3);
    check({req_pin, eot}, 2'h2, "low idle");
    wr_reg(16'h0049);
    dma_strobe(1'b0, 1'b0);
  endtask : t_dma

  task automatic t_irq();
    wr_reg(16'h0009);
    status = 8'h01;
    mask = 8'h01;
    hold(1);
    check(irq, 1'b0, "level low");
    mask = 8'h02;
    hold(1);
    check(irq, 1'b1, "masked");
    mask = 8'h01;
    wr_reg(16'h0008);
    check(irq, 1'b1, "gated");
    wr_reg(16'h000D);
    check(irq, 1'b1, "level high");
    status = 8'h00;
    wr_reg(16'h000B);
    status = 8'h01;
    hold(1);
    check(irq, 1'b0, "pulse start");
    hold(3);
    check(irq, 1'b0, "pulse last");
    hold(1);
    check(irq, 1'b1, "pulse end");
    hold(2);
    check(irq, 1'b1, "pulse idle");
    // a pulse is cut short once the request goes away
    status = 8'h00;
    hold(1);
    status = 8'h01;
    hold(2);
    check(irq, 1'b0, "pulse again");
    status = 8'h00;
    hold(1);
    check(irq, 1'b1, "pulse cut");
  endtask : t_irq

  ////////////////////////////////////////////////////////////////////////////////
  // hang guard, then the main sequence
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      conclude();
    end
  end

  initial begin
    hold(6);
    nrst = 1'b1;
    t_reset();
    t_fields();
    t_dma();
    t_irq();
    conclude();
  end
endmodule : host_hw_config_register_tb_top

// File: verification/hpc_cpu_model.sv
// processor model on the shared parallel bus of the pin configuration block
// assumes the device samples every pin through two flops on the same clock
module hpc_cpu_model (
  input  wire logic        i_clk_sys,
  input  wire logic [15:0] i_data,     // device read data
  input  wire logic        i_data_oe,  // device drives the bus
  output logic             o_cs_n,
  output logic             o_rd_n,
  output logic             o_wr_n,
  output logic             o_a0,
  output logic [15:0]      o_data
);
  timeunit 1ns;
  timeprecision 1ps;

  ////////////////////////////////////////////////////////////////////////////////
  // idle bus at time zero
  initial begin
    o_cs_n = 1'b1;
    o_rd_n = 1'b1;
    o_wr_n = 1'b1;
    o_a0   = 1'b0;
    o_data = 16'h0000;
  end

  // wait n edges, then step just past the edge
  task automatic hold(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask : hold

  ////////////////////////////////////////////////////////////////////////////////
  // one strobe: low five clocks, high four with cs, a0 and data kept,
  // because the device decodes writes only after the synced strobe rises
  task automatic cycle(input logic wr, input logic a0, input logic [15:0] d,
                       output logic [15:0] q, output logic oe);
    o_cs_n = 1'b0;
    o_a0   = a0;
    o_data = wr ? d : ~o_data;  // reads leave the line changing
    o_wr_n = !wr;
    o_rd_n = wr;
    hold(5);
    q      = i_data;
    oe     = i_data_oe;
    o_wr_n = 1'b1;
    o_rd_n = 1'b1;
    hold(4);
    o_cs_n = 1'b1;
    o_data = ~o_data;           // released bus never shows the old word
    hold(1);
  endtask : cycle
endmodule : hpc_cpu_model
